// File: verilog/ssom_top.sv
// Status flag generation, terminal mapping, monitors and register slave
`timescale 1ns/10ps
`default_nettype none
module ssom_top
  import ssom_pkg::*;
(
  input wire logic aclk,                     // System clock 40 MHz
  input wire logic aresetn,                  // Synchronous reset, low
  input wire logic [7:0] awaddr,             // Write address
  input wire logic awvalid,                  // Write address valid
  output logic awready,                      // Write address ready
  input wire logic [31:0] wdata,             // Write data
  input wire logic [3:0] wstrb,              // Write byte strobes
  input wire logic wvalid,                   // Write data valid
  output logic wready,                       // Write data ready
  output logic [1:0] bresp,                  // Write response
  output logic bvalid,                       // Write response valid
  input wire logic bready,                   // Write response ready
  input wire logic [7:0] araddr,             // Read address
  input wire logic arvalid,                  // Read address valid
  output logic arready,                      // Read address ready
  output logic [31:0] rdata,                 // Read data
  output logic [1:0] rresp,                  // Read response
  output logic rvalid,                       // Read data valid
  input wire logic rready,                   // Read data ready
  input wire logic signed [DW-1:0] cmd_speed,   // Commanded speed
  input wire logic signed [DW-1:0] motor_speed, // Measured speed
  input wire logic signed [DW-1:0] torque_cmd,  // Torque command
  input wire logic pos_cmd_pin,              // Positioning command pin
  input wire logic speed_ctrl_mode,          // Speed control mode
  input wire logic speed_cmd_applied,        // Speed command present
  input wire logic alarm_active,             // An alarm is present
  input wire logic alarm_clearable_class,    // Alarm is resettable
  input wire logic [N_WARN-1:0] warn_cond,   // Warning conditions
  input wire logic [15:0] load_ratio,        // Load ratio in percent
  output logic [N_OUT-1:0] out_term,         // Output terminals
  output logic speed_match_flag,             // Speed match
  output logic warning_flag_a,               // Warning A
  output logic warning_flag_b,               // Warning B
  output logic pos_cmd_flag,                 // Position command active
  output logic alarm_clearable_flag,         // Clearable alarm
  output logic speed_cmd_flag,               // Speed command active
  output logic overload_alarm,               // Overload trip
  output logic signed [DW-1:0] monitor_channel_1, // Monitor 1 in mV
  output logic signed [DW-1:0] monitor_channel_2  // Monitor 2 in mV
);
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [DW:0] abs_diff(input logic signed [DW-1:0] a,
                                           input logic signed [DW-1:0] b);
    logic signed [DW:0] d;
    d = {a[DW-1], a} - {b[DW-1], b};
    return d[DW] ? -d : d;
  endfunction : abs_diff

  function automatic logic signed [DW:0] pick(input logic [1:0] item);
    logic signed [DW:0] q;
    case (item)
      ITEM_MOTOR_SPEED: q = {motor_speed[DW-1], motor_speed};
      ITEM_CMD_SPEED: q = {cmd_speed[DW-1], cmd_speed};
      ITEM_TORQUE_CMD: q = {torque_cmd[DW-1], torque_cmd};
      default: q = {cmd_speed[DW-1], cmd_speed}
                 - {motor_speed[DW-1], motor_speed};
    endcase
    return q;
  endfunction : pick

  // Quantity to millivolts: q * 1000 / units-per-volt, then saturate
  function automatic logic signed [DW-1:0] mon_value(
      input logic signed [DW:0] q, input logic [15:0] scl,
      input logic abs_mode);
    logic signed [31:0] p;
    logic signed [31:0] v;
    p = 32'(q) * MV_PER_V;
    v = (scl == 16'h0000) ? 32'sd0 : p / $signed({16'h0000, scl});
    if (abs_mode && v < 0) begin
      v = -v;
    end
    if (v > MON_MAX) begin
      v = MON_MAX;
    end else if (v < MON_MIN) begin
      v = MON_MIN;
    end
    return v[DW-1:0];
  endfunction : mon_value

  logic [31:0] range_r;
  logic [31:0] wsel_r;
  logic [31:0] osel_r;
  logic [31:0] mcfg_r;
  logic [31:0] mscl_r;
  logic [31:0] olim_r;
  logic aw_got_r;
  logic [7:0] aw_addr_r;
  logic w_got_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_do;
  logic [7:0] wr_addr;
  logic wr_hit;
  logic [31:0] rd_nxt;
  logic rd_hit;
  logic pos_sync1_r;
  logic pos_sync2_r;
  logic sm_r;
  logic wa_r;
  logic wb_r;
  logic pos_r;
  logic almclr_r;
  logic spdcmd_r;
  logic [N_OUT-1:0] out_r;
  logic [7:0] fvec;
  logic signed [DW-1:0] mon1_r;
  logic signed [DW-1:0] mon2_r;
  logic [WSEL_W-1:0] wsel_a;
  logic [WSEL_W-1:0] wsel_b;
  logic method_abs;

  ssom_ovl_if ovl_bus();

  assign wsel_a = wsel_r[WSEL_A_LSB +: WSEL_W];
  assign wsel_b = wsel_r[WSEL_B_LSB +: WSEL_W];
  assign method_abs = mcfg_r[METHOD_BIT];

  // Write channel: address and data taken in either order
  assign awready = !aw_got_r && !bvalid_r;
  assign wready = !w_got_r && !bvalid_r;
  assign wr_do = aw_got_r && w_got_r && !bvalid_r;
  assign wr_addr = {aw_addr_r[7:2], 2'b00};
  assign wr_hit = (wr_addr == ADDR_RANGE) || (wr_addr == ADDR_WSEL)
               || (wr_addr == ADDR_OSEL) || (wr_addr == ADDR_MCFG)
               || (wr_addr == ADDR_MSCL) || (wr_addr == ADDR_OLIM)
               || (wr_addr == ADDR_OCLR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_got_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_do) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // Settings registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_r <= RANGE_RST;
      wsel_r <= WSEL_RST;
      osel_r <= OSEL_RST;
      mcfg_r <= MCFG_RST;
      mscl_r <= MSCL_RST;
      olim_r <= OLIM_RST;
    end else if (wr_do) begin
      case (wr_addr)
        ADDR_RANGE: range_r <= merge(range_r, w_data_r, w_strb_r)
                               & RANGE_MASK;
        ADDR_WSEL: wsel_r <= merge(wsel_r, w_data_r, w_strb_r) & WSEL_MASK;
        ADDR_OSEL: osel_r <= merge(osel_r, w_data_r, w_strb_r) & OSEL_MASK;
        ADDR_MCFG: mcfg_r <= merge(mcfg_r, w_data_r, w_strb_r) & MCFG_MASK;
        ADDR_MSCL: mscl_r <= merge(mscl_r, w_data_r, w_strb_r);
        ADDR_OLIM: olim_r <= merge(olim_r, w_data_r, w_strb_r);
        default: ;
      endcase
    end
  end

  // Write-one pulse that clears the overload alarm
  assign ovl_bus.clear = wr_do && (wr_addr == ADDR_OCLR) && w_strb_r[0]
                      && w_data_r[OCLR_BIT];
  assign ovl_bus.load_ratio = load_ratio;
  assign ovl_bus.limit = olim_r;

  ssom_ovl u_ovl (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(ovl_bus)
  );

  assign overload_alarm = ovl_bus.alarm;

  // Read channel
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({araddr[7:2], 2'b00})
      ADDR_RANGE: rd_nxt = range_r;
      ADDR_WSEL: rd_nxt = wsel_r;
      ADDR_OSEL: rd_nxt = osel_r;
      ADDR_MCFG: rd_nxt = mcfg_r;
      ADDR_MSCL: rd_nxt = mscl_r;
      ADDR_OLIM: rd_nxt = olim_r;
      ADDR_OCLR: rd_nxt = 32'h0000_0000;
      ADDR_STAT: rd_nxt = {20'h00000, out_r, 1'b0, overload_alarm,
                           spdcmd_r, almclr_r, pos_r, wb_r, wa_r, sm_r};
      ADDR_MON: rd_nxt = {mon2_r, mon1_r};
      ADDR_OACC: rd_nxt = ovl_bus.acc;
      default: rd_hit = 1'b0;
    endcase
  end

  assign arready = !rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_nxt;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // Pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_sync1_r <= 1'b0;
      pos_sync2_r <= 1'b0;
    end else begin
      pos_sync1_r <= pos_cmd_pin;
      pos_sync2_r <= pos_sync1_r;
    end
  end

  // Status flags, one evaluation per clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sm_r <= 1'b0;
      wa_r <= 1'b0;
      wb_r <= 1'b0;
      pos_r <= 1'b0;
      almclr_r <= 1'b0;
      spdcmd_r <= 1'b0;
    end else begin
      sm_r <= abs_diff(cmd_speed, motor_speed)
              <= {1'b0, range_r[DW-1:0]};
      wa_r <= warn_cond[wsel_a];
      wb_r <= warn_cond[wsel_b];
      pos_r <= pos_sync2_r;
      almclr_r <= alarm_active && alarm_clearable_class;
      spdcmd_r <= speed_ctrl_mode && speed_cmd_applied;
    end
  end

  assign speed_match_flag = sm_r;
  assign warning_flag_a = wa_r;
  assign warning_flag_b = wb_r;
  assign pos_cmd_flag = pos_r;
  assign alarm_clearable_flag = almclr_r;
  assign speed_cmd_flag = spdcmd_r;

  // Function code indexes this vector; code 0 is the inactive level
  assign fvec = {overload_alarm, spdcmd_r, almclr_r, pos_r,
                 wb_r, wa_r, sm_r, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= '0;
    end else begin
      for (int i = 0; i < N_OUT; i++) begin
        out_r[i] <= !osel_r[i*OSEL_W + 3]
                    && fvec[osel_r[i*OSEL_W +: 3]];
      end
    end
  end

  assign out_term = out_r;

  // Monitor channels share the output method bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon1_r <= '0;
      mon2_r <= '0;
    end else begin
      mon1_r <= mon_value(pick(mcfg_r[ITEM1_LSB +: 2]), mscl_r[15:0],
                          method_abs);
      mon2_r <= mon_value(pick(mcfg_r[ITEM2_LSB +: 2]), mscl_r[31:16],
                          method_abs);
    end
  end

  assign monitor_channel_1 = mon1_r;
  assign monitor_channel_2 = mon2_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_speed_match;
    (abs_diff(cmd_speed, motor_speed) > {1'b0, range_r[DW-1:0]})
      |=> !speed_match_flag;
  endproperty
  a_speed_match: assert property (p_speed_match)
    else $error("speed match high outside range");

  property p_speed_equal;
    (cmd_speed == motor_speed) |=> speed_match_flag;
  endproperty
  a_speed_equal: assert property (p_speed_equal)
    else $error("speed match low at equal speeds");

  property p_warn_a;
    warn_cond[wsel_a] |=> warning_flag_a;
  endproperty
  a_warn_a: assert property (p_warn_a)
    else $error("warning A missed its condition");

  sequence s_pin_high;
    pos_cmd_pin [*4];
  endsequence
  sequence s_pin_low;
    !pos_cmd_pin [*4];
  endsequence
  property p_pos_cmd;
    (s_pin_high |=> pos_cmd_flag) and (s_pin_low |=> !pos_cmd_flag);
  endproperty
  a_pos_cmd: assert property (p_pos_cmd)
    else $error("position command flag does not follow pin");

  property p_alm_clr;
    !(alarm_active && alarm_clearable_class) |=> !alarm_clearable_flag;
  endproperty
  a_alm_clr: assert property (p_alm_clr)
    else $error("clearable flag without clearable alarm");

  property p_spd_cmd;
    (speed_ctrl_mode && speed_cmd_applied) |=> speed_cmd_flag;
  endproperty
  a_spd_cmd: assert property (p_spd_cmd)
    else $error("speed command flag missing");

  property p_unmapped;
    (osel_r[3:0] == FN_NONE) [*2] |-> !out_term[0];
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unassigned terminal 0 is active");

  property p_unmapped_hi;
    osel_r[15] |=> !out_term[3];
  endproperty
  a_unmapped_hi: assert property (p_unmapped_hi)
    else $error("terminal 3 active with undefined code");

  property p_map_match;
    (osel_r[3:0] == FN_SPEED_MATCH) |=> out_term[0] == $past(sm_r);
  endproperty
  a_map_match: assert property (p_map_match)
    else $error("terminal 0 does not follow registered flag");

  property p_mon1_dflt;
    (mcfg_r[ITEM1_LSB +: 2] == ITEM_MOTOR_SPEED && !method_abs
     && mscl_r[15:0] == 16'h01f4 && motor_speed == 16'sh01f4)
      |=> monitor_channel_1 == 16'sh03e8;
  endproperty
  a_mon1_dflt: assert property (p_mon1_dflt)
    else $error("monitor 1 not 1 V at 500 r/min");

  property p_mon2_dflt;
    (mcfg_r[ITEM2_LSB +: 2] == ITEM_TORQUE_CMD && !method_abs
     && mscl_r[31:16] == 16'h0021 && torque_cmd == 16'sh0021)
      |=> monitor_channel_2 == 16'sh03e8;
  endproperty
  a_mon2_dflt: assert property (p_mon2_dflt)
    else $error("monitor 2 not 1 V at 33 percent");

  property p_method;
    method_abs |=> !monitor_channel_1[DW-1] && !monitor_channel_2[DW-1];
  endproperty
  a_method: assert property (p_method)
    else $error("absolute method gave a negative monitor");
endmodule : ssom_top
`default_nettype wire

// File: verilog/ssom_pkg.sv
// Constants shared by the servo status output mapper and its overload engine
// How it works
// - Speed match is high while |commanded - measured speed| is within the range setting.
// - Each of the two warning flags follows the warning condition picked by its own select field.
// - The position command flag follows the synchronised positioning command input.
// - The clearable-alarm flag is high only while an alarm is active and is of the resettable class.
// - The speed command flag is high when speed control mode is on and a speed command is applied.
// - Flags reach an output terminal only through one of four selection fields, all unassigned at reset.
// - Monitor channel 1 item and scale are set by software, default motor speed at 1 V per 500 r/min.
// - Monitor channel 2 item and scale are set by software, default torque command at 1 V per 33 %.
// - One shared output-method bit (signed or absolute) applies to both monitor channels.
// - An overload accumulator integrates load above rating and trips a sticky alarm past its limit.
package ssom_pkg;
  localparam int unsigned DW = 16;
  localparam logic [7:0] ADDR_RANGE = 8'h00;
  localparam logic [7:0] ADDR_WSEL = 8'h04;
  localparam logic [7:0] ADDR_OSEL = 8'h08;
  localparam logic [7:0] ADDR_MCFG = 8'h0c;
  localparam logic [7:0] ADDR_MSCL = 8'h10;
  localparam logic [7:0] ADDR_OLIM = 8'h14;
  localparam logic [7:0] ADDR_OCLR = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1c;
  localparam logic [7:0] ADDR_MON = 8'h20;
  localparam logic [7:0] ADDR_OACC = 8'h24;
  localparam logic [31:0] RANGE_RST = 32'h0000_0032;
  localparam logic [31:0] WSEL_RST = 32'h0000_0000;
  localparam logic [31:0] OSEL_RST = 32'h0000_0000;
  localparam logic [31:0] MCFG_RST = 32'h0000_0200;
  localparam logic [31:0] MSCL_RST = 32'h0021_01f4;
  localparam logic [31:0] OLIM_RST = 32'h0010_0000;
  localparam logic [31:0] RANGE_MASK = 32'h0000_ffff;
  localparam logic [31:0] WSEL_MASK = 32'h0000_0707;
  localparam logic [31:0] OSEL_MASK = 32'h0000_ffff;
  localparam logic [31:0] MCFG_MASK = 32'h0001_0303;
  localparam int unsigned WSEL_A_LSB = 0;
  localparam int unsigned WSEL_B_LSB = 8;
  localparam int unsigned WSEL_W = 3;
  localparam int unsigned OSEL_W = 4;
  localparam int unsigned N_OUT = 4;
  localparam int unsigned N_WARN = 8;
  localparam int unsigned ITEM1_LSB = 0;
  localparam int unsigned ITEM2_LSB = 8;
  localparam int unsigned METHOD_BIT = 16;
  localparam int unsigned OCLR_BIT = 0;
  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_SPEED_MATCH = 4'h1;
  localparam logic [3:0] FN_WARN_A = 4'h2;
  localparam logic [3:0] FN_WARN_B = 4'h3;
  localparam logic [3:0] FN_POS_CMD = 4'h4;
  localparam logic [3:0] FN_ALM_CLR = 4'h5;
  localparam logic [3:0] FN_SPD_CMD = 4'h6;
  localparam logic [3:0] FN_OVL = 4'h7;
  localparam logic [1:0] ITEM_MOTOR_SPEED = 2'h0;
  localparam logic [1:0] ITEM_CMD_SPEED = 2'h1;
  localparam logic [1:0] ITEM_TORQUE_CMD = 2'h2;
  localparam logic [1:0] ITEM_SPEED_ERR = 2'h3;
  localparam int signed MV_PER_V = 1000;
  localparam int signed MON_MAX = 32767;
  localparam int signed MON_MIN = -32768;
  localparam logic [15:0] RATED_LOAD = 16'h0064;
  localparam logic [31:0] OVL_DECAY = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ssom_pkg

// File: verilog/ssom_ovl_if.sv
// Link between the mapper and its overload accumulator
`timescale 1ns/10ps
`default_nettype none
interface ssom_ovl_if;
  logic [15:0] load_ratio;
  logic [31:0] limit;
  logic clear;
  logic alarm;
  logic [31:0] acc;
  modport ctl(output load_ratio, output limit, output clear,
              input alarm, input acc);
  modport eng(input load_ratio, input limit, input clear,
              output alarm, output acc);
endinterface : ssom_ovl_if
`default_nettype wire

// File: verilog/ssom_ovl.sv
// Overload accumulator with sticky trip alarm
`timescale 1ns/10ps
`default_nettype none
module ssom_ovl
  import ssom_pkg::*;
(
  input wire logic aclk,    // System clock
  input wire logic aresetn, // Synchronous reset, active low
  ssom_ovl_if.eng bus       // Load in, alarm out
);
  logic [31:0] acc_r;
  logic alarm_r;
  logic [15:0] excess;
  logic [32:0] sum;

  always_comb begin
    excess = (bus.load_ratio > RATED_LOAD) ? bus.load_ratio - RATED_LOAD
                                           : 16'h0000;
    sum = {1'b0, acc_r} + {17'h00000, excess};
  end

  // Integrate above rating, bleed off at or below it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= 32'h0000_0000;
    end else if (excess != 16'h0000) begin
      acc_r <= sum[32] ? 32'hffff_ffff : sum[31:0];
    end else begin
      acc_r <= (acc_r > OVL_DECAY) ? acc_r - OVL_DECAY : 32'h0000_0000;
    end
  end

  // Trip wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_r <= 1'b0;
    end else if (acc_r > bus.limit) begin
      alarm_r <= 1'b1;
    end else if (bus.clear) begin
      alarm_r <= 1'b0;
    end
  end

  assign bus.alarm = alarm_r;
  assign bus.acc = acc_r;

  property p_ovl_trip;
    @(posedge aclk) disable iff (!aresetn)
      (acc_r > bus.limit) |=> bus.alarm;
  endproperty
  a_ovl_trip: assert property (p_ovl_trip)
    else $error("overload alarm did not trip");

  property p_ovl_hold;
    @(posedge aclk) disable iff (!aresetn)
      (bus.alarm && !bus.clear) |=> bus.alarm;
  endproperty
  a_ovl_hold: assert property (p_ovl_hold)
    else $error("overload alarm dropped without clear");
endmodule : ssom_ovl
`default_nettype wire

// File: sim/ssom_host.sv
// Host controller model latching the drive's output terminals
`timescale 1ns/10ps
`default_nettype none
module ssom_host (
  input wire logic aclk, // System clock
  input wire logic [3:0] term, // Drive output terminals
  output logic [3:0] seen // Terminals as last latched
);
  always_ff @(posedge aclk) begin
    seen <= term;
  end
endmodule : ssom_host
`default_nettype wire

// File: sim/ssom_top_test.sv
// Self-checking bench for the status output mapper
`timescale 1ns/10ps
`default_nettype none
module ssom_top_test
  import ssom_pkg::*;
();
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0, out_term, host_seen;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic signed [DW-1:0] cmd_speed = 0, motor_speed = 0, torque_cmd = 0;
  logic pos_cmd_pin = 0, speed_ctrl_mode = 0, speed_cmd_applied = 0;
  logic alarm_active = 0, alarm_clearable_class = 0;
  logic [7:0] warn_cond = 0;
  logic [15:0] load_ratio = 0;
  logic speed_match_flag, warning_flag_a, warning_flag_b, pos_cmd_flag;
  logic alarm_clearable_flag, speed_cmd_flag, overload_alarm;
  logic signed [DW-1:0] monitor_channel_1, monitor_channel_2;
  logic [15:0] fm = 16'h0026;
  int miscompares = 0;
  int checks = 0;

  always #12.5 aclk = ~aclk;

  ssom_top u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .cmd_speed, .motor_speed,
    .torque_cmd, .pos_cmd_pin, .speed_ctrl_mode, .speed_cmd_applied,
    .alarm_active, .alarm_clearable_class, .warn_cond, .load_ratio,
    .out_term, .speed_match_flag, .warning_flag_a, .warning_flag_b,
    .pos_cmd_flag, .alarm_clearable_flag, .speed_cmd_flag, .overload_alarm,
    .monitor_channel_1, .monitor_channel_2);

  ssom_host u_host (.aclk, .term(out_term), .seen(host_seen));

  task end_sim;
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task hang;
    miscompares++;
    end_sim;
  endtask : hang

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("ERROR %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
      if (n > 40) hang;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    tick(1);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
      if (n > 40) hang;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp);
    chk(32'(rresp), 32'(er));
    tick(1);
  endtask : rd

  task t_reset;
    rd(ADDR_RANGE, RANGE_RST, RESP_OKAY);
    rd(ADDR_WSEL, WSEL_RST, RESP_OKAY);
    rd(ADDR_OSEL, OSEL_RST, RESP_OKAY);
    rd(ADDR_MCFG, MCFG_RST, RESP_OKAY);
    rd(ADDR_MSCL, 32'h0021_01f4, RESP_OKAY);
    rd(ADDR_OLIM, OLIM_RST, RESP_OKAY);
    rd(8'h30, 32'h0, RESP_SLVERR);
    wr(8'h30, 32'h1, RESP_SLVERR);
    chk(32'(out_term), 32'h0);
  endtask : t_reset

  task t_match;
    int r;
    int i;
    cmd_speed <= 16'sh03e8;
    for (r = 50; r > 0; r -= 40) begin
      wr(ADDR_RANGE, 32'(r), RESP_OKAY);
      for (i = 0; i < 4; i++) begin
        motor_speed <= 16'(i < 2 ? 1000 + r + i : 1002 - r - i);
        tick(3);
        chk(32'(speed_match_flag), 32'(i % 2 == 0));
      end
    end
  endtask : t_match

  task t_warn;
    int i;
    wr(ADDR_WSEL, 32'h0000_0503, RESP_OKAY);
    for (i = 0; i < 8; i++) begin
      warn_cond <= 8'(1 << i);
      tick(3);
      chk(32'({warning_flag_b, warning_flag_a}), 32'({i == 5, i == 3}));
    end
  endtask : t_warn

  task t_flags;
    int i;
    pos_cmd_pin <= 1'b1;
    tick(5);
    chk(32'(pos_cmd_flag), 32'h1);
    pos_cmd_pin <= 1'b0;
    tick(5);
    chk(32'(pos_cmd_flag), 32'h0);
    for (i = 0; i < 4; i++) begin
      {alarm_active, alarm_clearable_class} <= 2'(i);
      {speed_ctrl_mode, speed_cmd_applied} <= 2'(i);
      tick(3);
      chk(32'(alarm_clearable_flag), 32'(i == 3));
      chk(32'(speed_cmd_flag), 32'(i == 3));
    end
  endtask : t_flags

  task t_map;
    int c;
    int p;
    for (p = 0; p < 2; p++) begin
      motor_speed <= p ? 16'sh0000 : 16'sh03e8;
      warn_cond <= p ? 8'h20 : 8'h08;
      pos_cmd_pin <= 1'(p);
      {alarm_active, alarm_clearable_class} <= p ? 2'h0 : 2'h3;
      {speed_ctrl_mode, speed_cmd_applied} <= p ? 2'h3 : 2'h2;
      fm = p ? 16'h0058 : 16'h0026;
      for (c = 0; c < 16; c++) begin
        wr(ADDR_OSEL, 32'({4'(c), 4'h0, 4'(c), 4'(c)}), RESP_OKAY);
        tick(3);
        chk(32'(host_seen), 32'({fm[c], 1'b0, fm[c], fm[c]}));
      end
      rd(ADDR_STAT, 32'(p ? 8'h2c : 8'h13), RESP_OKAY);
    end
  endtask : t_map

  task t_mon;
    motor_speed <= 16'sh01f4;
    torque_cmd <= 16'sh0021;
    tick(3);
    rd(ADDR_MON, 32'h03e8_03e8, RESP_OKAY);
    motor_speed <= -16'sh03e8;
    torque_cmd <= 16'sh0042;
    tick(3);
    rd(ADDR_MON, 32'h07d0_f830, RESP_OKAY);
    torque_cmd <= -16'sh0042;
    wr(ADDR_MCFG, 32'h0001_0200, RESP_OKAY);
    rd(ADDR_MON, 32'h07d0_07d0, RESP_OKAY);
    wr(ADDR_MCFG, 32'h0000_0301, RESP_OKAY);
    wr(ADDR_MSCL, 32'h000a_03e8, RESP_OKAY);
    rd(ADDR_MON, 32'h7fff_03e8, RESP_OKAY);
  endtask : t_mon

  task t_ovl;
    int n;
    load_ratio <= 16'h0064;
    tick(20);
    chk(32'(overload_alarm), 32'h0);
    wr(ADDR_OLIM, 32'h0000_0014, RESP_OKAY);
    load_ratio <= 16'h0069;
    n = 0;
    while (overload_alarm !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    chk(32'(n >= 5 && n <= 9), 32'h1);
    load_ratio <= 16'h0000;
    tick(40);
    chk(32'(overload_alarm), 32'h1);
    rd(ADDR_OACC, 32'h0, RESP_OKAY);
    wr(ADDR_OSEL, 32'h0000_0700, RESP_OKAY);
    chk(32'(out_term), 32'h4);
    wr(ADDR_OCLR, 32'h1, RESP_OKAY);
    tick(2);
    chk(32'(overload_alarm), 32'h0);
    chk(32'(out_term), 32'h0);
  endtask : t_ovl

  initial begin
    tick(20);
    aresetn <= 1'b1;
    tick(1);
    t_reset;
    t_match;
    t_warn;
    t_flags;
    t_map;
    t_mon;
    t_ovl;
    end_sim;
  end
endmodule : ssom_top_test
`default_nettype wire
